//--- logic/sar_pkg.sv
/*
 * shared constants and carrier types of the serial converter readout.
 * assumes a 125 MHz system clock sampling the serial pins.
 */
package sar_pkg;

  // resolution of the converter core
  localparam int unsigned DATA_BITS    = 8;
  // leading zero bit periods at frame start
  localparam int unsigned LEAD_ZEROS   = 3;
  // clock falling edge that ends a frame
  localparam int unsigned FRAME_FALLS  = 16;
  // falls needed before a rise is not an abort
  localparam int unsigned ABORT_FALLS  = 10;
  // fall at which the core is fully enabled
  localparam int unsigned WAKE_FALL    = 3;
  // width of the falling edge counter
  localparam int unsigned CNT_W        = 5;

  // idle levels of the two input pins
  localparam logic SEL_IDLE  = 1'b1;
  localparam logic SCLK_IDLE = 1'b1;

  // one-hot frame states
  typedef enum logic [2:0] {
    ST_DOWN    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } sar_state_type;

  // serial data pin: level and output enable
  typedef struct packed {
    logic data;
    logic oe;
  } sar_pin_type;

endpackage

//--- logic/sar_pin_sync.sv
/*
 * two-flop synchroniser with edge detection for one pin.
 * assumes the pin is asynchronous to i_clk.
 */
`timescale 1ns/10ps
module sar_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall,
  output logic      o_rise
);

  logic meta_q;  // first stage, read only by sync_q
  logic sync_q;  // second stage, safe level
  logic prev_q;  // delayed level for edges

  ////////////////////////////////////////////////////////////////////
  // synchroniser chain
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // edges from the safe stages only
  assign o_level = sync_q;
  assign o_fall  = prev_q & ~sync_q;
  assign o_rise  = ~prev_q & sync_q;

endmodule

//--- logic/sar_shifter.sv
/*
 * result shift register, msb first, zeros shifted in behind.
 * assumes load and shift are never asserted together.
 */
`timescale 1ns/10ps
module sar_shifter #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic         i_shift,
  input  wire logic [W-1:0] i_data,
  output logic              o_next_bit
);

  logic [W-1:0] sh_q;  // remaining result bits
  logic [W-1:0] sh_d;  // next contents

  ////////////////////////////////////////////////////////////////////
  // next contents and the bit that goes out with it
  assign sh_d = i_load  ? i_data :
                i_shift ? {sh_q[W-2:0], 1'b0} : sh_q;
  assign o_next_bit = sh_d[W-1];

  ////////////////////////////////////////////////////////////////////
  // register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

endmodule

//--- logic/sar_readout.sv
/*
 * conversion and readout control of a serial successive
 * approximation converter with automatic power-down.
 * assumes the select and serial clock pins are asynchronous to
 * I_CLK and slow enough for edge detection (sclk period >= 4 clk);
 * I_ANALOG_INPUT is the quantised front end value on I_CLK.
 */
// What this block does
// - conversion starts on select low plus clocks
// - result msb first during conversion, no latency
// - three zero bits precede the result
// - sixteenth fall releases data pin, ends cycle
// - each select low period is one frame
// - select fall wakes device from power-down
// - fully enabled from third clock fall
// - sixteenth fall flags end, powers down
// - select rise before ten falls aborts frame
// - sampling ends at third clock fall
// - conversion spans third to sixteenth clock fall
`timescale 1ns/10ps
module sar_readout
  import sar_pkg::*;
#(
  parameter int unsigned DATA_BITS = sar_pkg::DATA_BITS
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_CONV_SELECT_N,
  input  wire logic                 I_SERIAL_CLOCK_IN,
  input  wire logic [DATA_BITS-1:0] I_ANALOG_INPUT,
  output sar_pkg::sar_pin_type      O_SERIAL_RESULT_OUT,
  output logic                      O_AWAKE,
  output logic                      O_FULL_ENABLE,
  output logic                      O_SAMPLING,
  output logic                      O_END_OF_CONV,
  output logic                      O_RESULT_VALID
);

  import sar_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // constants at counter width
  localparam logic [CNT_W-1:0] C_WAKE  = CNT_W'(WAKE_FALL);
  localparam logic [CNT_W-1:0] C_LEAD  = CNT_W'(LEAD_ZEROS);
  localparam logic [CNT_W-1:0] C_ABORT = CNT_W'(ABORT_FALLS);
  localparam logic [CNT_W-1:0] C_FRAME = CNT_W'(FRAME_FALLS);
  localparam logic [CNT_W-1:0] C_DEND  = CNT_W'(LEAD_ZEROS + DATA_BITS);
  localparam logic [CNT_W-1:0] C_ONE   = CNT_W'(1);

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic                 sel_lvl;      // synchronised select level
  logic                 sel_fall;     // select went low
  logic                 sel_rise;     // select went high
  logic                 sclk_fall;    // serial clock falling edge
  sar_state_type        st_q;         // frame state
  sar_state_type        st_d;
  logic [CNT_W-1:0]     cnt_q;        // falls seen in this frame
  logic [CNT_W-1:0]     cnt_d;
  logic [CNT_W-1:0]     cnt_inc;      // count after this fall
  sar_pin_type          pin_q;        // data pin register
  sar_pin_type          pin_d;
  logic                 awake_q;      // core powered
  logic                 awake_d;
  logic                 full_q;       // core fully enabled
  logic                 full_d;
  logic                 samp_q;       // track phase
  logic                 samp_d;
  logic                 eoc_q;        // end of conversion pulse
  logic                 eoc_d;
  logic                 poison_q;     // next frame carries no result
  logic                 poison_d;
  logic                 ok_q;         // current frame result valid
  logic                 ok_d;
  logic                 busy;         // inside a frame
  logic                 start;        // frame begins now
  logic                 hold_edge;    // third fall: sample held
  logic                 end_edge;     // sixteenth fall
  logic                 abort;        // early select rise
  logic                 early_end;    // late rise, frame cut short
  logic                 shift;        // move to next result bit
  logic                 next_bit;     // bit the shifter presents
  logic [DATA_BITS-1:0] load_val;     // sample, or zeros if poisoned

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  sar_pin_sync #(
    .RST_VAL (SEL_IDLE)
  ) u_sel_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_pin   (I_CONV_SELECT_N),
    .o_level (sel_lvl),
    .o_fall  (sel_fall),
    .o_rise  (sel_rise)
  );

  sar_pin_sync #(
    .RST_VAL (SCLK_IDLE)
  ) u_sclk_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_pin   (I_SERIAL_CLOCK_IN),
    .o_level (),
    .o_fall  (sclk_fall),
    .o_rise  ()
  );

  ////////////////////////////////////////////////////////////////////
  // frame events
  assign busy    = (st_q != ST_DOWN);
  assign cnt_inc = cnt_q + C_ONE;
  assign start   = (st_q == ST_DOWN) && sel_fall;
  assign hold_edge = (st_q == ST_SAMPLE) && sclk_fall && !sel_rise
                     && (cnt_inc == C_WAKE);
  assign end_edge  = (st_q == ST_CONVERT) && sclk_fall && !sel_rise
                     && (cnt_inc == C_FRAME);
  assign abort     = busy && sel_rise && (cnt_q < C_ABORT);
  assign early_end = busy && sel_rise && (cnt_q >= C_ABORT);
  // next bit on every later fall but the sixteenth
  assign shift     = (st_q == ST_CONVERT) && sclk_fall && !sel_rise
                     && !end_edge;
  // poisoned frame loads zeros instead of the sample
  assign load_val  = ok_q ? I_ANALOG_INPUT : '0;

  ////////////////////////////////////////////////////////////////////
  // result shifter
  sar_shifter #(
    .W (DATA_BITS)
  ) u_shift (
    .i_clk      (I_CLK),
    .i_rst_n    (I_RST_N),
    .i_load     (hold_edge),
    .i_shift    (shift),
    .i_data     (load_val),
    .o_next_bit (next_bit)
  );

  ////////////////////////////////////////////////////////////////////
  // next state and counter
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_DOWN: begin
        if (start) begin
          st_d  = ST_SAMPLE;
          cnt_d = '0;
        end
      end
      ST_SAMPLE: begin
        if (sel_rise) begin
          st_d = ST_DOWN;
        end else if (hold_edge) begin
          st_d  = ST_CONVERT;
          cnt_d = cnt_inc;
        end else if (sclk_fall) begin
          cnt_d = cnt_inc;
        end
      end
      ST_CONVERT: begin
        if (sel_rise || end_edge) begin
          st_d = ST_DOWN;
        end
        if (sclk_fall && !sel_rise) begin
          cnt_d = cnt_inc;
        end
      end
      default: begin
        st_d = ST_DOWN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // data pin
  always_comb begin
    pin_d = pin_q;
    if (start) begin
      pin_d.oe   = 1'b1;
      pin_d.data = 1'b0;
    end else if (sel_rise || end_edge) begin
      pin_d.oe   = 1'b0;
      pin_d.data = 1'b0;
    end else if (hold_edge || shift) begin
      pin_d.data = next_bit;
    end else if ((st_q == ST_SAMPLE) && sclk_fall) begin
      pin_d.data = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power and phase flags
  // wake on start, sleep at end
  assign awake_d = start ? 1'b1 :
                   (end_edge || sel_rise) ? 1'b0 : awake_q;
  assign full_d  = hold_edge ? 1'b1 :
                   (end_edge || sel_rise) ? 1'b0 : full_q;
  // sampling from select fall to third fall
  assign samp_d  = start ? 1'b1 :
                   (hold_edge || sel_rise) ? 1'b0 : samp_q;
  assign eoc_d   = end_edge || early_end;
  // abort spoils the next frame, start consumes the flag
  assign poison_d = abort ? 1'b1 : start ? 1'b0 : poison_q;
  assign ok_d     = start ? !poison_q : (abort ? 1'b0 : ok_q);

  ////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q  <= ST_DOWN;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output and flag registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_q    <= '0;
      awake_q  <= 1'b0;
      full_q   <= 1'b0;
      samp_q   <= 1'b0;
      eoc_q    <= 1'b0;
      poison_q <= 1'b0;
      ok_q     <= 1'b0;
    end else begin
      pin_q    <= pin_d;
      awake_q  <= awake_d;
      full_q   <= full_d;
      samp_q   <= samp_d;
      eoc_q    <= eoc_d;
      poison_q <= poison_d;
      ok_q     <= ok_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign O_SERIAL_RESULT_OUT = pin_q;
  assign O_AWAKE             = awake_q;
  assign O_FULL_ENABLE       = full_q;
  assign O_SAMPLING          = samp_q;
  assign O_END_OF_CONV       = eoc_q;
  assign O_RESULT_VALID      = ok_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_START_ON_SELECT: assert property (
    $rose(st_q == ST_SAMPLE) |-> $past(sel_fall) && !sel_lvl)
    else $error("frame began without select fall");

  AST_MSB_NO_DELAY: assert property (
    hold_edge && ok_q |=> pin_q.data == $past(I_ANALOG_INPUT[DATA_BITS-1]))
    else $error("msb not presented at third fall");

  AST_LEAD_ZEROS: assert property (
    pin_q.oe && (cnt_q < C_LEAD) |-> !pin_q.data)
    else $error("leading bit not zero");

  AST_RELEASE_16: assert property (
    end_edge |=> !pin_q.oe && (st_q == ST_DOWN) && (cnt_q == C_FRAME))
    else $error("pin not released at sixteenth fall");

  AST_ONE_FRAME: assert property (
    (st_q == ST_DOWN) && !sel_fall |=> (st_q == ST_DOWN))
    else $error("frame started without fresh select fall");

  AST_WAKE: assert property (
    start |=> awake_q && pin_q.oe && !pin_q.data)
    else $error("no wake on select fall");

  AST_FULL_ENABLE: assert property (
    full_q |-> (cnt_q >= C_WAKE) && awake_q)
    else $error("enabled before third fall");

  AST_EOC_SLEEP: assert property (
    end_edge |=> eoc_q && !awake_q ##1 !eoc_q)
    else $error("end of conversion not flagged");

  AST_ABORT: assert property (
    abort |=> poison_q && !awake_q && !ok_q)
    else $error("early rise did not abort");

  AST_HOLD_AT_3: assert property (
    samp_q |-> (cnt_q < C_WAKE) && (st_q == ST_SAMPLE))
    else $error("sampling past third fall");

  AST_CONV_SPAN: assert property (
    (st_q == ST_CONVERT) |-> (cnt_q >= C_WAKE) && (cnt_q < C_FRAME))
    else $error("conversion outside its span");

  AST_HIZ_HIGH: assert property (
    sel_lvl && $past(sel_lvl) |-> !pin_q.oe)
    else $error("pin driven while select high");

  AST_TRAIL_ZERO: assert property (
    pin_q.oe && (cnt_q >= C_DEND) |-> !pin_q.data)
    else $error("trailing bit not zero");

endmodule

//--- tb/sar_host_model.sv
/*
 * host model: drives select and serial clock, reads the data wire.
 * assumes the bench calls its tasks and gives it the 8 ns clock.
 */
`timescale 1ns/10ps
module sar_host_model
  import sar_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire sar_pkg::sar_pin_type i_pin,
  output logic                      o_sel_n,
  output logic                      o_sclk
);
  logic last_q = 1'b0;  // wire level one cycle ago
  logic wire_lvl;  // level the host sees on the data wire

  // released wire: no pull, so it toggles every cycle
  assign wire_lvl = i_pin.oe ? i_pin.data : ~last_q;

  // remember the wire for the released case
  always @(posedge i_clk) begin
    last_q <= wire_lvl;
  end

  // idle pins at time zero
  initial begin
    o_sel_n = 1'b1;
    o_sclk  = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // select opens frame
  // select low, serial clock idles high, return bit 0
  task automatic sel_low(output logic b);
    @(negedge i_clk);
    o_sel_n = 1'b0;
    repeat (4) @(negedge i_clk);
    b = wire_lvl;
  endtask

  // one 64 ns serial clock period, bit read before the rise
  task automatic pulse(output logic b);
    @(negedge i_clk);
    o_sclk = 1'b0;
    repeat (4) @(negedge i_clk);
    b = wire_lvl;
    o_sclk = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask

  // one microsecond high
  // select high, then 128 cycles: a cut frame releases the data
  // pin three cycles after the rise, and 1 us must follow that
  task automatic sel_high();
    @(negedge i_clk);
    o_sel_n = 1'b1;
    repeat (128) @(negedge i_clk);
  endtask
endmodule

//--- tb/sar_readout_bench.sv
/*
 * self-checking bench of the serial converter readout.
 * assumes the host model drives the pins; bench drives the rest.
 */
`timescale 1ns/10ps
module sar_readout_bench;
  import sar_pkg::*;

  logic        i_clk;      // 125 MHz clock
  logic        i_rst_n;    // async reset
  logic        sel_n;      // select from host
  logic        sclk;       // serial clock from host
  logic [7:0]  analog;     // quantised input value
  sar_pin_type pin;        // data pin level and enable
  logic        awake;      // core powered
  logic        full_en;    // fully enabled
  logic        sampling;   // track phase
  logic        eoc;        // end of conversion pulse
  logic        valid;      // frame carries a result
  int          bad_count;  // mismatches
  int          checked;    // comparisons
  int          end_cnt;    // end pulses seen
  int          cycles;     // run length

  sar_readout #(.DATA_BITS(DATA_BITS)) i_dut (
    .I_CLK               (i_clk),
    .I_RST_N             (i_rst_n),
    .I_CONV_SELECT_N     (sel_n),
    .I_SERIAL_CLOCK_IN   (sclk),
    .I_ANALOG_INPUT      (analog),
    .O_SERIAL_RESULT_OUT (pin),
    .O_AWAKE             (awake),
    .O_FULL_ENABLE       (full_en),
    .O_SAMPLING          (sampling),
    .O_END_OF_CONV       (eoc),
    .O_RESULT_VALID      (valid)
  );

  sar_host_model i_host (
    .i_clk   (i_clk),
    .i_pin   (pin),
    .o_sel_n (sel_n),
    .o_sclk  (sclk)
  );

  //////////////////////////////////////////////////////////////////////
  // clock, end pulse counter and hang limit
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (eoc === 1'b1) begin
      end_cnt++;
    end
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one frame of given falls; good says a result is expected
  task automatic frame(input logic [7:0] val, input int falls,
                       input logic good);
    logic [15:0] got;
    logic [15:0] exp;
    logic        b;
    int          e0;
    analog = val;
    e0 = end_cnt;
    got = 16'h0000;
    exp = good ? {3'b000, val, 5'b00000} : 16'h0000;
    i_host.sel_low(b);
    got[15] = b;
    check({12'h000, awake, sampling, full_en, pin.oe}, 16'h000d);
    for (int n = 1; n <= falls; n++) begin
      i_host.pulse(b);
      if (n < 16) begin
        got[15-n] = b;
      end
      if (n == 2) begin
        check({12'h000, awake, sampling, full_en, pin.oe}, 16'h000d);
      end
      if (n == 3) begin
        check({12'h000, awake, sampling, full_en, valid},
              {12'h000, 3'b101, good});
      end
    end
    if (falls >= 16) begin
      check(got, exp);
      check({13'h0000, awake, full_en, pin.oe}, 16'h0000);
    end
    i_host.sel_high();
    check({13'h0000, awake, full_en, pin.oe}, 16'h0000);
    check(16'(end_cnt - e0), (falls >= 10) ? 16'h0001 : 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_idle();
    logic b;
    int   e0;
    e0 = end_cnt;
    repeat (3) i_host.pulse(b);
    check({14'h0000, awake, pin.oe}, 16'h0000);
    check(16'(end_cnt - e0), 16'h0000);
  endtask

  task automatic s_normal();
    frame(8'ha5, 16, 1'b1);
    frame(8'h5a, 16, 1'b1);
    frame(8'hff, 16, 1'b1);
    frame(8'h00, 16, 1'b1);
    frame(8'h81, 18, 1'b1);
  endtask

  task automatic s_abort();
    frame(8'h3c, 9, 1'b1);
    frame(8'h3c, 16, 1'b0);
    frame(8'h3c, 16, 1'b1);
  endtask

  task automatic s_late();
    frame(8'hc3, 10, 1'b1);
    frame(8'hc3, 16, 1'b1);
  endtask

  task automatic s_reset();
    logic b;
    i_host.sel_low(b);
    repeat (5) i_host.pulse(b);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    i_host.sel_high();
    check({11'h000, awake, full_en, sampling, eoc, pin.oe},
          16'h0000);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    frame(8'h96, 16, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    i_rst_n = 1'b0;
    analog  = 8'h00;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    s_idle();
    s_normal();
    s_abort();
    s_late();
    s_reset();
    final_report();
  end
endmodule
